// ===== rtl/async_host_port_with_reset.sv
// Functional notes
// - Address bus is 15 bits, bit zero least significant.
// - Data bus is bidirectional, 16 bits, bit zero least significant.
// - Access happens only while strobe and chip select are both low.
// - Direction line picks direction; device drives data only on reads.
// - Completion of each transfer shown by driving acknowledge low.
// - Reset asserts asynchronously, releases synchronously to the clock.
// - In reset serial outputs are high or high impedance per select pins.
// - Reset drives all channel buffer enable outputs low.
// - Reset loads sequencer and output registers; pin synchronisers and memory are not reset.
// - In reset, local select low: outputs driven high; high: high impedance.
module async_host_port_with_reset
  import host_port_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W,
  parameter int SN = STREAM_N,
  parameter int BN = BUF_EN_N
)
(
  // Clock, enable and reset
  input wire logic CLK,
  input wire logic CE,
  input wire logic RST_N,
  // Host port pins
  input wire logic [AW-1:0] HOST_ADDRESS_LINES,
  input wire logic [DW-1:0] HOST_DATA_LINES_IN,
  output logic [DW-1:0] HOST_DATA_LINES_OUT,
  output logic HOST_DATA_LINES_OE,
  input wire logic CHIP_SELECT_N,
  input wire logic ACCESS_STROBE_N,
  input wire logic READ_WRITE,
  output logic TRANSFER_ACK_N_OUT,
  output logic TRANSFER_ACK_N_OE,
  // Output control pins
  input wire logic LOCAL_RESET_LEVEL_SELECT,
  input wire logic BACKPLANE_RESET_LEVEL_SELECT,
  input wire logic OUTPUT_DRIVE_ENABLE,
  // Switch core side
  input wire logic [SN-1:0] CORE_LOCAL_DATA,
  input wire logic [SN-1:0] CORE_LOCAL_OE,
  input wire logic [SN-1:0] CORE_BACKPLANE_DATA,
  input wire logic [SN-1:0] CORE_BACKPLANE_OE,
  input wire logic [BN-1:0] CORE_LOCAL_BUFFER_ENABLE,
  input wire logic [BN-1:0] CORE_BACKPLANE_BUFFER_ENABLE,
  // Serial and buffer control pins
  output logic [SN-1:0] LOCAL_SERIAL_OUT,
  output logic [SN-1:0] LOCAL_SERIAL_OE,
  output logic [SN-1:0] BACKPLANE_SERIAL_OUT,
  output logic [SN-1:0] BACKPLANE_SERIAL_OE,
  output logic [BN-1:0] LOCAL_BUFFER_ENABLE,
  output logic [BN-1:0] BACKPLANE_BUFFER_ENABLE
);

  // ---------------------------------------------------------------
  // Reset synchroniser
  // ---------------------------------------------------------------
  logic rst_meta_n;
  logic rst_sync_n;

  // Assert at once, release after two clean edges
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else if (CE)
    begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  localparam int PIN_W = AW + DW + 6;

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  logic [PIN_W-1:0] next_pin_meta;
  logic [PIN_W-1:0] next_pin_sync;

  assign pin_raw = {HOST_ADDRESS_LINES, HOST_DATA_LINES_IN, CHIP_SELECT_N,
                    ACCESS_STROBE_N, READ_WRITE, LOCAL_RESET_LEVEL_SELECT,
                    BACKPLANE_RESET_LEVEL_SELECT, OUTPUT_DRIVE_ENABLE};

  always_comb
  begin
    next_pin_meta = pin_meta;
    next_pin_sync = pin_sync;
    if (CE)
    begin
      next_pin_meta = pin_raw;
      next_pin_sync = pin_meta;
    end
  end

  always_ff @(posedge CLK)
  begin
    pin_meta <= next_pin_meta;
    pin_sync <= next_pin_sync;
  end

  logic [AW-1:0] addr_s;
  logic [DW-1:0] wdata_s;
  logic cs_n_s;
  logic strobe_n_s;
  logic rw_s;
  logic lsel_s;
  logic bsel_s;
  logic ode_s;

  assign {addr_s, wdata_s, cs_n_s, strobe_n_s, rw_s, lsel_s, bsel_s,
          ode_s} = pin_sync;

  // ---------------------------------------------------------------
  // Host port sequencer
  // ---------------------------------------------------------------
  port_state_t state;
  port_state_t next_state;
  logic access;
  logic mem_wr;
  logic mem_rd;
  logic drive_read;
  logic next_drive_read;
  logic [DW-1:0] mem_rdata;

  assign access = !cs_n_s && !strobe_n_s;

  always_comb
  begin
    next_state = state;
    next_drive_read = drive_read;
    mem_wr = 1'b0;
    mem_rd = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (access)
        begin
          if (rw_s == READ_LEVEL)
          begin
            mem_rd = 1'b1;
            next_drive_read = 1'b1;
            next_state = ST_READ;
          end
          else
          begin
            mem_wr = 1'b1;
            next_state = ST_ACK;
          end
        end
      end
      ST_READ: next_state = ST_ACK;
      ST_ACK:
      begin
        if (!access)
        begin
          next_drive_read = 1'b0;
          next_state = ST_RELEASE;
        end
      end
      ST_RELEASE: next_state = ST_IDLE;
      default:
      begin
        next_state = ST_IDLE;
        next_drive_read = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (!rst_sync_n)
    begin
      state <= ST_IDLE;
      drive_read <= 1'b0;
    end
    else if (CE)
    begin
      state <= next_state;
      drive_read <= next_drive_read;
    end
  end

  host_port_mem #(
    .AW(AW),
    .DW(DW)
  ) u_mem (
    .clk(CLK),
    .ce(CE),
    .wr_en(mem_wr && rst_sync_n),
    .wr_addr(addr_s),
    .wr_data(wdata_s),
    .rd_en(mem_rd && rst_sync_n),
    .rd_addr(addr_s),
    .rd_data(mem_rdata)
  );

  // Acknowledge low while held, one high cycle, then released
  always_comb
  begin
    TRANSFER_ACK_N_OUT = ACK_IDLE;
    TRANSFER_ACK_N_OE = 1'b0;
    if (rst_sync_n && state == ST_ACK)
    begin
      TRANSFER_ACK_N_OUT = ACK_ACTIVE;
      TRANSFER_ACK_N_OE = 1'b1;
    end
    else if (rst_sync_n && state == ST_RELEASE)
    begin
      TRANSFER_ACK_N_OUT = ACK_IDLE;
      TRANSFER_ACK_N_OE = 1'b1;
    end
  end

  assign HOST_DATA_LINES_OE = rst_sync_n && drive_read;
  assign HOST_DATA_LINES_OUT = mem_rdata;

  // ---------------------------------------------------------------
  // Serial and buffer control outputs
  // ---------------------------------------------------------------
  logic [SN-1:0] lso;
  logic [SN-1:0] lsoe;
  logic [SN-1:0] bso;
  logic [SN-1:0] bsoe;
  logic [BN-1:0] lbe;
  logic [BN-1:0] bbe;
  logic [SN-1:0] next_lso;
  logic [SN-1:0] next_lsoe;
  logic [SN-1:0] next_bso;
  logic [SN-1:0] next_bsoe;
  logic [BN-1:0] next_lbe;
  logic [BN-1:0] next_bbe;

  // Select high hands drive to the enable pin and core
  function automatic logic [SN-1:0] run_oe(input logic sel,
                                           input logic output_drive_enable,
                                           input logic [SN-1:0] core_oe);
    run_oe = sel ? (core_oe & {SN{output_drive_enable}}) : {SN{1'b1}};
  endfunction : run_oe

  always_comb
  begin
    next_lso = lso;
    next_lsoe = lsoe;
    next_bso = bso;
    next_bsoe = bsoe;
    next_lbe = lbe;
    next_bbe = bbe;
    if (CE)
    begin
      next_lso = CORE_LOCAL_DATA;
      next_lsoe = run_oe(lsel_s, ode_s, CORE_LOCAL_OE);
      next_bso = CORE_BACKPLANE_DATA;
      next_bsoe = run_oe(bsel_s, ode_s, CORE_BACKPLANE_OE);
      next_lbe = CORE_LOCAL_BUFFER_ENABLE;
      next_bbe = CORE_BACKPLANE_BUFFER_ENABLE;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!rst_sync_n)
    begin
      lso <= {SN{SERIAL_RESET_LEVEL}};
      lsoe <= {SN{!lsel_s}};
      bso <= {SN{SERIAL_RESET_LEVEL}};
      bsoe <= {SN{!bsel_s}};
      lbe <= {BN{BUF_EN_RESET}};
      bbe <= {BN{BUF_EN_RESET}};
    end
    else
    begin
      lso <= next_lso;
      lsoe <= next_lsoe;
      bso <= next_bso;
      bsoe <= next_bsoe;
      lbe <= next_lbe;
      bbe <= next_bbe;
    end
  end

  // Reset state forced straight from the asynchronously asserted reset
  assign LOCAL_SERIAL_OUT = rst_sync_n ? lso : {SN{SERIAL_RESET_LEVEL}};
  assign BACKPLANE_SERIAL_OUT = rst_sync_n ? bso : {SN{SERIAL_RESET_LEVEL}};
  assign LOCAL_SERIAL_OE = rst_sync_n ? lsoe : {SN{!lsel_s}};
  assign BACKPLANE_SERIAL_OE = rst_sync_n ? bsoe : {SN{!bsel_s}};
  assign LOCAL_BUFFER_ENABLE = rst_sync_n ? lbe : {BN{BUF_EN_RESET}};
  assign BACKPLANE_BUFFER_ENABLE =
    rst_sync_n ? bbe : {BN{BUF_EN_RESET}};

endmodule : async_host_port_with_reset

// ===== rtl/host_port_pkg.sv
package host_port_pkg;
  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int DATA_W = 16;
  localparam int STREAM_N = 16;
  localparam int BUF_EN_N = 2;
  localparam int SYNC_STAGES = 2;

  // ---------------------------------------------------------------
  // Pin levels and reset values
  // ---------------------------------------------------------------
  localparam logic READ_LEVEL = 1'b1;
  localparam logic ACK_ACTIVE = 1'b0;
  localparam logic ACK_IDLE = 1'b1;
  localparam logic SERIAL_RESET_LEVEL = 1'b1;
  localparam logic BUF_EN_RESET = 1'b0;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // Host port states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_ACK = 2'b10,
    ST_RELEASE = 2'b11
  } port_state_t;
endpackage : host_port_pkg

// ===== rtl/host_port_mem.sv
module host_port_mem
  import host_port_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
)
(
  // Clock
  input wire logic clk,
  input wire logic ce,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  // Read port
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);

  logic [DW-1:0] words [0:(2**AW)-1];

  always_ff @(posedge clk)
  begin
    if (ce && wr_en)
    begin
      words[wr_addr] <= wr_data;
    end
    if (ce && rd_en)
    begin
      rd_data <= words[rd_addr];
    end
  end

endmodule : host_port_mem

// ===== tb/async_host_port_with_reset_asserts.sv
module host_port_checker
  import host_port_pkg::*;
#(
  parameter int SN = STREAM_N,
  parameter int BN = BUF_EN_N
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Host port
  input wire logic CHIP_SELECT_N,
  input wire logic ACCESS_STROBE_N,
  input wire logic READ_WRITE,
  input wire logic HOST_DATA_LINES_OE,
  input wire logic TRANSFER_ACK_N_OUT,
  input wire logic TRANSFER_ACK_N_OE,
  // Serial and buffer pins
  input wire logic [SN-1:0] LOCAL_SERIAL_OUT,
  input wire logic [SN-1:0] BACKPLANE_SERIAL_OUT,
  input wire logic [BN-1:0] LOCAL_BUFFER_ENABLE,
  input wire logic [BN-1:0] BACKPLANE_BUFFER_ENABLE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  wire logic ack = TRANSFER_ACK_N_OE && !TRANSFER_ACK_N_OUT;

  a_reset_buffers_off: assert property (disable iff (1'b0)
    !RST_N |-> LOCAL_BUFFER_ENABLE == '0 && BACKPLANE_BUFFER_ENABLE == '0)
    else $error("buffer enable high in reset");
  a_reset_serial_high: assert property (disable iff (1'b0)
    !RST_N |-> &LOCAL_SERIAL_OUT && &BACKPLANE_SERIAL_OUT)
    else $error("serial out low in reset");
  a_ack_needs_strobe: assert property (
    $rose(ack) |-> $past(!CHIP_SELECT_N && !ACCESS_STROBE_N))
    else $error("ack without access");
  a_write_ack_time: assert property (
    $fell(ACCESS_STROBE_N) && !CHIP_SELECT_N |-> ##[1:6] ack)
    else $error("ack late");
  a_ack_driven_high: assert property (
    ack |=> TRANSFER_ACK_N_OE)
    else $error("ack floated while low");
  a_ack_drop_bound: assert property (
    $rose(ACCESS_STROBE_N) |-> ##[1:6] !TRANSFER_ACK_N_OE)
    else $error("ack not released");
  a_read_drives_data: assert property (
    $rose(HOST_DATA_LINES_OE) |-> $past(READ_WRITE && !ACCESS_STROBE_N))
    else $error("data driven on write");
  a_idle_no_ack: assert property (
    CHIP_SELECT_N [*6] |-> !TRANSFER_ACK_N_OE)
    else $error("ack while deselected");

  c_read: cover property ($rose(ack) && READ_WRITE);
  c_write: cover property ($rose(ack) && !READ_WRITE);
  c_release: cover property ($rose(ACCESS_STROBE_N) && ack);
endmodule : host_port_checker

bind async_host_port_with_reset host_port_checker #(.SN(SN), .BN(BN)) chk (
  .CLK, .RST_N, .CHIP_SELECT_N, .ACCESS_STROBE_N, .READ_WRITE,
  .HOST_DATA_LINES_OE, .TRANSFER_ACK_N_OUT, .TRANSFER_ACK_N_OE,
  .LOCAL_SERIAL_OUT, .BACKPLANE_SERIAL_OUT, .LOCAL_BUFFER_ENABLE,
  .BACKPLANE_BUFFER_ENABLE);

// ===== tb/host_cpu_model.sv
module host_cpu_model
  import host_port_pkg::*;
(
  // Clock and acknowledge
  input wire logic clk,
  input wire logic ack_n,
  // Request
  output logic cs_n,
  output logic strobe_n,
  output logic rw,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    cs_n = 1'b1;
    strobe_n = 1'b1;
    rw = READ_LEVEL;
    addr = '0;
    wdata = '0;
  end

  // Hold request until acknowledged, then keep the gap
  task automatic access(input logic sel, input logic r,
    input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
    input int slow, output logic ok);
    int n;
    cs_n <= !sel;
    strobe_n <= 1'b0;
    rw <= r;
    addr <= a;
    wdata <= r ? ~wdata : d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack_n !== ACK_ACTIVE && n < 12);
    ok = ack_n === ACK_ACTIVE;
    repeat (slow) @(posedge clk);
    cs_n <= 1'b1;
    strobe_n <= 1'b1;
    wdata <= ~wdata;
    n = 0;
    while (ack_n !== ACK_IDLE && n < 12)
    begin
      @(posedge clk);
      n++;
    end
    repeat (3) @(posedge clk);
  endtask : access
endmodule : host_cpu_model

// ===== tb/async_host_port_with_reset_tb_top.sv
module async_host_port_with_reset_tb_top
  import host_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b1;
  logic lsel = 1'b0;
  logic bsel = 1'b1;
  logic output_drive_enable = 1'b0;
  logic [STREAM_N-1:0] c_ld = '0, c_lo = '0, c_bd = '0, c_bo = '0;
  logic [BUF_EN_N-1:0] c_lb = '0, c_bb = '0, lbe, bbe;
  logic [STREAM_N-1:0] lso, lsoe, bso, bsoe;
  logic [DATA_W-1:0] dout, hdata;
  logic doe, ack_out, ack_oe, cs_n, strobe_n, rw;
  logic ack_prev = 1'b1;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] exp_q [$];
  int n_mismatch = 0;
  int samples_checked = 0;
  int run_cnt = 0;
  logic [3*DATA_W-1:0] core_prev;
  wire logic ack_n = ack_oe ? ack_out : ACK_IDLE;
  wire logic [DATA_W-1:0] bus = doe ? dout : hdata;

  async_host_port_with_reset dut (.CLK(clk), .CE(1'b1), .RST_N(rst_n),
    .HOST_ADDRESS_LINES(addr), .HOST_DATA_LINES_IN(bus),
    .HOST_DATA_LINES_OUT(dout), .HOST_DATA_LINES_OE(doe),
    .CHIP_SELECT_N(cs_n), .ACCESS_STROBE_N(strobe_n), .READ_WRITE(rw),
    .TRANSFER_ACK_N_OUT(ack_out), .TRANSFER_ACK_N_OE(ack_oe),
    .LOCAL_RESET_LEVEL_SELECT(lsel), .BACKPLANE_RESET_LEVEL_SELECT(bsel),
    .OUTPUT_DRIVE_ENABLE(output_drive_enable), .CORE_LOCAL_DATA(c_ld), .CORE_LOCAL_OE(c_lo),
    .CORE_BACKPLANE_DATA(c_bd), .CORE_BACKPLANE_OE(c_bo),
    .CORE_LOCAL_BUFFER_ENABLE(c_lb), .CORE_BACKPLANE_BUFFER_ENABLE(c_bb),
    .LOCAL_SERIAL_OUT(lso), .LOCAL_SERIAL_OE(lsoe),
    .BACKPLANE_SERIAL_OUT(bso), .BACKPLANE_SERIAL_OE(bsoe),
    .LOCAL_BUFFER_ENABLE(lbe), .BACKPLANE_BUFFER_ENABLE(bbe));
  host_cpu_model host (.clk(clk), .ack_n(ack_n), .cs_n(cs_n),
    .strobe_n(strobe_n), .rw(rw), .addr(addr), .wdata(hdata));

  always #5 clk = ~clk;

  always @(posedge clk)
  begin
    {c_ld, c_lo, c_bd, c_bo} <= {$urandom, $urandom};
    {c_lb, c_bb, output_drive_enable} <= 5'($urandom);
  end

  task automatic check(input logic [DATA_W-1:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Read data compared at each new acknowledge
  always @(negedge clk)
  begin
    ack_prev <= ack_n;
    if (ack_prev === 1'b1 && ack_n === ACK_ACTIVE && doe === 1'b1)
      check(dout, exp_q.size() ? exp_q.pop_front() : 'x);
  end

  // Serial and buffer pins follow the core one cycle late
  always @(negedge clk)
  begin
    run_cnt <= rst_n ? run_cnt + 1 : 0;
    core_prev <= {c_ld, c_bd, DATA_W'({c_lb, c_bb})};
    if (rst_n && run_cnt > 4)
    begin
      check(lso, core_prev[47:32]);
      check(bso, core_prev[31:16]);
      check(DATA_W'({lbe, bbe}), core_prev[15:0]);
      check(lsel ? bsoe : lsoe, '1);
    end
  end

  task automatic chk_reset();
    check(lso & bso, '1);
    check(lsoe, {STREAM_N{~lsel}});
    check(bsoe, {STREAM_N{~bsel}});
    check(DATA_W'({lbe, bbe, doe, ack_oe}), '0);
  endtask : chk_reset

  task automatic op(input logic sel, r, input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] d;
    logic ok;
    d = DATA_W'($urandom);
    if (r)
      exp_q.push_back(mem[a]);
    else if (sel)
      mem[a] = d;
    host.access(sel, r, a, d, $urandom_range(4), ok);
    check(DATA_W'(ok), DATA_W'(sel));
  endtask : op

  task automatic run_ops();
    logic [ADDR_W-1:0] a [3];
    a = '{'0, '1, ADDR_W'($urandom)};
    foreach (a[i]) op(1'b1, 1'b0, a[i]);
    op(1'b0, 1'b0, a[0]);
    for (int i = 0; i < 12; i++) op(1'b1, i[0], a[i % 3]);
    foreach (a[i]) op(1'b1, 1'b1, a[i]);
  endtask : run_ops

  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    void'($urandom(76153));
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    #1 chk_reset();
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    run_ops();
    rst_n <= 1'b0;
    #2 chk_reset();
    @(posedge clk);
    {lsel, bsel} <= 2'h2;
    repeat (10) @(posedge clk);
    #1 chk_reset();
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    run_ops();
    check(DATA_W'(exp_q.size()), '0);
    report_and_stop();
  end

  initial
  begin
    #50us;
    n_mismatch++;
    report_and_stop();
  end
endmodule : async_host_port_with_reset_tb_top
